// [verilog/sram_burst_ctrl.sv]
`timescale 1ns/1ps
// ==========================================================================
// Memory controller end: makes the link clock and runs one burst at a time
module sram_burst_ctrl import sram_link_pkg::*; (
  // Clock and reset
  input logic ref_clk,
  input logic sys_rst,
  // Link to the memory
  sram_link.ctrl lk,
  // Requests
  input logic req_valid,
  output logic req_ready,
  input logic req_write,
  input logic [ADDR_W-1:0] req_addr,
  input logic [BURST_W-1:0] req_wdata,
  input logic [MASK_W-1:0] req_bw_n,
  // Read data
  output logic rsp_valid,
  input logic rsp_ready,
  output logic [BURST_W-1:0] rsp_data,
  // Loop control and status
  input logic dll_reset_req,
  input logic clk_stop,
  input logic use_k_timing,
  output logic link_ready
);

  typedef enum logic [2:0] {
    ST_LOCK = 3'b000,
    ST_IDLE = 3'b001,
    ST_BURST = 3'b010,
    ST_DOFF = 3'b011,
    ST_HALT = 3'b100
  } ctrl_state_e;

  // ========================================================================
  // Declarations
  ctrl_state_e state;
  logic [CNT_W-1:0] cnt;
  logic [2:0] slot;
  logic ph;
  logic run;
  logic step;
  logic issue;
  logic op_write;
  logic [ADDR_W-1:0] op_addr;
  logic [BURST_W-1:0] op_data;
  logic [MASK_W-1:0] op_mask;
  logic [BURST_W-1:0] cap;
  logic push;
  logic pop;
  logic [1:0] fifo_cnt;
  logic wp;
  logic rp;
  logic [BURST_W-1:0] fifo_mem [0:1];
  logic [2:0] wbeat;
  logic [2:0] rbeat;

  // ========================================================================
  // Link clock
  // Divide by two; held low while halted so the memory sees a still clock.
  assign run = (state != ST_HALT);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= 1'b0;
    end else begin
      ph <= run & ~ph;
    end
  end
  assign lk.beat_clk = ph;
  // Outputs change as the link clock falls, half a beat before the memory
  assign step = run & ph;

  // ========================================================================
  // Request acceptance
  // Only on a step that precedes a true-clock rise, and a read only when
  // the answer buffer has room for its burst.
  assign req_ready = (state == ST_IDLE) & step & ~lk.k_rise &
                     ~dll_reset_req & ~clk_stop &
                     (req_write | (fifo_cnt != 2'h2));
  assign issue = req_valid & req_ready;
  assign link_ready = (state == ST_IDLE) | (state == ST_BURST);
  assign wbeat = slot - WR_SLOT0;
  assign rbeat = slot - RD_SLOT0;

  // ========================================================================
  // Sequencer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_LOCK;
      cnt <= '0;
      slot <= 3'h0;
      lk.doff_n <= 1'b1;
      lk.clk_held <= 1'b0;
    end else begin
      unique case (state)
        ST_LOCK: begin
          if (step) begin
            if (cnt == LOCK_WAIT_LAST) begin
              state <= ST_IDLE;
            end
            cnt <= cnt + 1'b1;
          end
        end
        ST_IDLE: begin
          cnt <= '0;
          if (dll_reset_req) begin
            state <= ST_DOFF;
            lk.doff_n <= 1'b0;
          end else if (clk_stop && step) begin
            state <= ST_HALT;
          end else if (issue) begin
            state <= ST_BURST;
            slot <= 3'h1;
          end
        end
        ST_BURST: begin
          if (step) begin
            slot <= slot + 1'b1;
            if (slot == SLOT_LAST) begin
              state <= ST_IDLE;
              slot <= 3'h0;
            end
          end
        end
        ST_DOFF: begin
          if (cnt == DOFF_LAST) begin
            lk.doff_n <= 1'b1;
            state <= ST_LOCK;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_HALT: begin
          if (cnt == K_STATIC_LAST) begin
            lk.clk_held <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
          // Restart only after the loop is known to be reset, then relock
          if (!clk_stop && lk.clk_held) begin
            lk.clk_held <= 1'b0;
            state <= ST_LOCK;
            cnt <= '0;
          end
        end
        default: begin
          state <= ST_LOCK;
        end
      endcase
    end
  end

  // ========================================================================
  // Burst operands held for the whole slot
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_write <= 1'b0;
      op_addr <= '0;
      op_data <= '0;
      op_mask <= '1;
    end else if (issue) begin
      op_write <= req_write;
      op_addr <= req_addr;
      op_data <= req_wdata;
      op_mask <= req_bw_n;
    end
  end

  // ========================================================================
  // Link command and write data pins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk.k_rise <= 1'b0;
      lk.rd_n <= 1'b1;
      lk.wr_n <= 1'b1;
      lk.addr <= '0;
      lk.d <= '0;
      lk.byte_write_mask_n <= MASK_NONE;
    end else if (step) begin
      lk.k_rise <= ~lk.k_rise;
      lk.rd_n <= ~(issue & ~req_write);
      lk.wr_n <= ~(issue & req_write);
      if (issue) begin
        lk.addr <= req_addr;
      end
      if (state == ST_BURST && op_write && slot >= WR_SLOT0 &&
          slot < WR_SLOT0 + 3'(BEAT_N)) begin
        lk.d <= op_data[wbeat[1:0]*DATA_W +: DATA_W];
        lk.byte_write_mask_n <= op_mask[wbeat[1:0]*BYTE_N +: BYTE_N];
      end else begin
        lk.byte_write_mask_n <= MASK_NONE;
      end
    end
  end

  // Output clock pair: tie both high to ask for input clock timing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk.c_pair <= 2'h0;
    end else begin
      lk.c_pair <= use_k_timing ? 2'h3 : {~ph, ph};
    end
  end

  // ========================================================================
  // Read capture
  // The memory drives q from the link clock made here, so q is stable at
  // each step and needs no resynchronising.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap <= '0;
      push <= 1'b0;
    end else begin
      push <= 1'b0;
      if (step && state == ST_BURST && !op_write && slot >= RD_SLOT0) begin
        cap[rbeat[1:0]*DATA_W +: DATA_W] <= lk.q;
        push <= (slot == SLOT_LAST);
      end
    end
  end

  // ========================================================================
  // Two-entry answer buffer; full stalls req_ready for reads
  assign pop = rsp_valid & rsp_ready;
  assign rsp_valid = (fifo_cnt != 2'h0);
  assign rsp_data = fifo_mem[rp];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem[wp] <= cap;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp <= 1'b0;
      rp <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      wp <= wp ^ push;
      rp <= rp ^ pop;
      fifo_cnt <= fifo_cnt + 2'(push) - 2'(pop);
    end
  end

endmodule : sram_burst_ctrl

// [common/sram_link_pkg.sv]
// ==========================================================================
// Shared constants for the burst-of-four memory link
package sram_link_pkg;
  // Geometry of one word, one burst and the array
  localparam int DATA_W = 18;
  localparam int BYTE_N = 2;
  localparam int BYTE_W = DATA_W / BYTE_N;
  localparam int ADDR_W = 4;
  localparam int WORDS = 1 << ADDR_W;
  localparam int BEAT_N = 4;
  localparam int BURST_W = DATA_W * BEAT_N;
  localparam int MASK_W = BYTE_N * BEAT_N;
  localparam logic [BYTE_N-1:0] MASK_NONE = 2'h3;

  // Clocking: one beat per merged rising edge of the input clock pair
  localparam int REF_PERIOD_NS = 40;
  localparam int BEATS_PER_K = 2;

  // Beats from a command edge to its first data beat
  localparam int WR_DATA_DELAY = 2;
  localparam int RD_DATA_DELAY = 3;
  localparam int WR_STAGE0 = WR_DATA_DELAY - 1;
  localparam int RD_STAGE0 = RD_DATA_DELAY - 1;
  localparam int PIPE_N = RD_STAGE0 + BEAT_N;

  // Controller slot: command, data and read capture, then back to idle
  localparam int SLOT_BEATS = 8;
  localparam logic [2:0] SLOT_LAST = 3'(SLOT_BEATS - 1);
  localparam logic [2:0] WR_SLOT0 = 3'(WR_DATA_DELAY);
  localparam logic [2:0] RD_SLOT0 = 3'(RD_DATA_DELAY + 1);

  // Least time in ns to a count of reference cycles, never below one
  function automatic int ns_to_cyc_min(input int ns);
    int c;
    c = (ns + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_min

  // Loop lock, loop-disable pulse and clock-static reset
  localparam int LOCK_K_CYC = 1024;
  localparam int LOCK_BEATS = LOCK_K_CYC * BEATS_PER_K;
  localparam int LOCK_W = $clog2(LOCK_BEATS);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_BEATS - 1);
  localparam int LOCK_MARGIN = 4;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] LOCK_WAIT_LAST =
    CNT_W'(LOCK_BEATS + LOCK_MARGIN - 1);
  localparam int DOFF_LOW_NS = 5;
  localparam int DOFF_LOW_CYC = ns_to_cyc_min(DOFF_LOW_NS);
  localparam logic [CNT_W-1:0] DOFF_LAST = CNT_W'(DOFF_LOW_CYC - 1);
  localparam int K_STATIC_NS = 30;
  localparam int K_STATIC_CYC = ns_to_cyc_min(K_STATIC_NS);
  localparam logic [CNT_W-1:0] K_STATIC_LAST = CNT_W'(K_STATIC_CYC - 1);
endpackage : sram_link_pkg

// [common/sram_link.sv]
`timescale 1ns/1ps
// ==========================================================================
// Pins between the memory controller and the memory
interface sram_link import sram_link_pkg::*; ();
  logic beat_clk;
  logic k_rise;
  logic doff_n;
  logic clk_held;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [BYTE_N-1:0] byte_write_mask_n;
  logic [1:0] c_pair;
  logic [DATA_W-1:0] q;
  logic q_oe;
  logic [1:0] echo_strobe_pair;

  // Controller end makes the clock and drives every command pin
  modport ctrl (
    output beat_clk, k_rise, doff_n, clk_held, rd_n, wr_n, addr, d,
    output byte_write_mask_n, c_pair,
    input q, q_oe, echo_strobe_pair
  );

  // Memory end is clocked by the link clock
  modport mem (
    input beat_clk, k_rise, doff_n, clk_held, rd_n, wr_n, addr, d,
    input byte_write_mask_n, c_pair,
    output q, q_oe, echo_strobe_pair
  );
endinterface : sram_link

// [verilog/sram_burst_mem.sv]
`timescale 1ns/1ps
module sram_burst_mem import sram_link_pkg::*; (
  // Link to the controller
  sram_link.mem lk,
  // Reset
  input logic sys_rst,
  // Device status
  output logic dll_locked,
  output logic out_from_k
);

  // ========================================================================
  // Declarations
  logic dll_clear;
  logic lrst_meta;
  logic lrst;
  logic drst_meta;
  logic drst;
  logic [LOCK_W-1:0] lock_cnt;
  logic [1:0] cp_meta;
  logic [1:0] cp_sync;
  logic take_rd;
  logic take_wr;
  logic take_nop;
  logic [PIPE_N-1:0] rd_v;
  logic [PIPE_N-1:0] wr_v;
  logic [PIPE_N-1:0] nop_v;
  logic [ADDR_W-1:0] rd_a [0:PIPE_N-1];
  logic [ADDR_W-1:0] wr_a [0:PIPE_N-1];
  logic [DATA_W-1:0] mem [0:WORDS-1][0:BEAT_N-1];

  // ========================================================================
  // Resets
  // Loop reset: any of the three causes clears the lock at once. The
  // release is taken through two flops so that the counter leaves reset
  // cleanly even though doff_n and clk_held come from another domain.
  assign dll_clear = sys_rst | ~lk.doff_n | lk.clk_held;

  // Loop reset release
  always_ff @(posedge lk.beat_clk or posedge dll_clear) begin
    if (dll_clear) begin
      lrst_meta <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_meta <= 1'b0;
      lrst <= lrst_meta;
    end
  end

  // Datapath reset release, same scheme on the system reset only
  always_ff @(posedge lk.beat_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drst_meta <= 1'b1;
      drst <= 1'b1;
    end else begin
      drst_meta <= 1'b0;
      drst <= drst_meta;
    end
  end

  // ========================================================================
  // Delay-locked loop model
  // A stopped clock can only reset the loop from the outside: with
  // no edges arriving, nothing here can count, so the controller raises
  // clk_held once the clock has been still long enough and that level
  // clears the lock asynchronously.
  // The count runs on beat edges, two per input clock cycle, so the wait
  // in input clock cycles is the full lock interval.
  always_ff @(posedge lk.beat_clk or posedge lrst) begin
    if (lrst) begin
      lock_cnt <= '0;
      dll_locked <= 1'b0;
    end else if (!dll_locked) begin
      if (lock_cnt == LOCK_LAST) begin
        dll_locked <= 1'b1;
      end
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // ========================================================================
  // Output clock selection
  // The output clock pair is a level from the controller's domain, so it
  // passes two flops before the selector looks at it.
  always_ff @(posedge lk.beat_clk or posedge drst) begin
    if (drst) begin
      cp_meta <= 2'h0;
      cp_sync <= 2'h0;
    end else begin
      cp_meta <= lk.c_pair;
      cp_sync <= cp_meta;
    end
  end

  // Both output clocks high selects input clock timing
  assign out_from_k = &cp_sync;

  // Echo strobes follow the selected clock
  // Out of reset the pair is complementary, so either half can time a capture
  always_ff @(posedge lk.beat_clk or posedge drst) begin
    if (drst) begin
      lk.echo_strobe_pair <= 2'h0;
    end else if (out_from_k) begin
      lk.echo_strobe_pair <= {~lk.k_rise, lk.k_rise};
    end else begin
      lk.echo_strobe_pair <= {~cp_sync[0], cp_sync[0]};
    end
  end

  // ========================================================================
  // Command capture
  // Commands count only on beats that are rising edges of the true clock;
  // the controller marks those with k_rise. Read and write may share an
  // edge, since the two ports are independent.
  assign take_rd = lk.k_rise & ~lk.rd_n;
  assign take_wr = lk.k_rise & ~lk.wr_n;
  assign take_nop = lk.k_rise & lk.rd_n & lk.wr_n;

  // Per-beat history of taken commands
  // No-op edges are kept too, since they are what turn the outputs off
  always_ff @(posedge lk.beat_clk or posedge drst) begin
    if (drst) begin
      rd_v <= '0;
      wr_v <= '0;
      nop_v <= '0;
    end else begin
      rd_v <= {rd_v[PIPE_N-2:0], take_rd};
      wr_v <= {wr_v[PIPE_N-2:0], take_wr};
      nop_v <= {nop_v[PIPE_N-2:0], take_nop};
    end
  end

  // Addresses travel with the history; no reset needed
  always_ff @(posedge lk.beat_clk) begin
    rd_a[0] <= lk.addr;
    wr_a[0] <= lk.addr;
    for (int j = 1; j < PIPE_N; j++) begin
      rd_a[j] <= rd_a[j-1];
      wr_a[j] <= wr_a[j-1];
    end
  end

  // ========================================================================
  // Array write
  // Beat i of a write arrives WR_DATA_DELAY + i edges after its command.
  // Writes to one port come at most every other cycle, so only one stage
  // can be live at a time.
  // Masked bytes keep the old contents of that beat only.
  always_ff @(posedge lk.beat_clk) begin
    for (int i = 0; i < BEAT_N; i++) begin
      if (wr_v[WR_STAGE0 + i]) begin
        for (int b = 0; b < BYTE_N; b++) begin
          if (!lk.byte_write_mask_n[b]) begin
            mem[wr_a[WR_STAGE0 + i]][i][b*BYTE_W +: BYTE_W] <=
              lk.d[b*BYTE_W +: BYTE_W];
          end
        end
      end
    end
  end

  // ========================================================================
  // Read data
  // Each read beat is fetched from the array at the edge it is driven,
  // not when the read was taken. A write to the same address taken on or
  // before the read edge has stored that beat at least one edge earlier, so the
  // freshly written data comes back instead of the old contents. The
  // trade: no separate forwarding buffer, but the array read port sits
  // right in front of the output register.
  // Beats leave in burst order, first beat first.
  always_ff @(posedge lk.beat_clk or posedge drst) begin
    if (drst) begin
      lk.q <= '0;
    end else begin
      for (int i = 0; i < BEAT_N; i++) begin
        if (rd_v[RD_STAGE0 + i]) begin
          lk.q <= mem[rd_a[RD_STAGE0 + i]][i];
        end
      end
    end
  end

  // ========================================================================
  // Output enable
  // A read beat turns the outputs on; they stay on, holding the last beat,
  // until a no-op edge has aged by one and a half cycles with no read beat due.
  // Limitation: with the enable low q still holds its last beat, so the
  // controller must only trust q inside its own read slots.
  always_ff @(posedge lk.beat_clk or posedge drst) begin
    if (drst) begin
      lk.q_oe <= 1'b0;
    end else if (|rd_v[RD_STAGE0 +: BEAT_N]) begin
      lk.q_oe <= 1'b1;
    end else if (nop_v[RD_STAGE0]) begin
      lk.q_oe <= 1'b0;
    end
  end

endmodule : sram_burst_mem

// [testbench/sram_link_assertions.sv]
`timescale 1ns/1ps
// ==========================================================================
// Protocol watch on the memory link pins, link clock domain only
module sram_link_assertions (
  // Link clock and reset
  input logic beat_clk,
  input logic sys_rst,
  // Loop control and commands
  input logic k_rise,
  input logic doff_n,
  input logic clk_held,
  input logic rd_n,
  input logic wr_n,
  // Read side
  input logic q_oe
);
  // Every check samples on a beat edge, quiet during reset
  default clocking cb @(posedge beat_clk);
  endclocking
  default disable iff (sys_rst);

  property p_rd_on_k;
    !rd_n |-> k_rise;
  endproperty
  a_rd_on_k: assert property (p_rd_on_k)
    else $error("read command off a true-clock edge");

  property p_wr_on_k;
    !wr_n |-> k_rise;
  endproperty
  a_wr_on_k: assert property (p_wr_on_k)
    else $error("write command off a true-clock edge");

  property p_one_cmd;
    !rd_n |-> wr_n;
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("read and write on the same edge");

  // A burst owns eight beats, so no command may follow inside them
  property p_rd_gap;
    !rd_n |=> (rd_n && wr_n) [*7];
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("command inside a read burst");

  property p_wr_gap;
    !wr_n |=> (rd_n && wr_n) [*7];
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("command inside a write burst");

  property p_k_toggle;
    k_rise |=> !k_rise;
  endproperty
  a_k_toggle: assert property (p_k_toggle)
    else $error("true-clock marker held two beats");

  // Four read beats drive the outputs, 1.5 cycles after the command
  property p_rd_burst;
    (!rd_n && k_rise) |-> ##4 q_oe [*4];
  endproperty
  a_rd_burst: assert property (p_rd_burst)
    else $error("read beats not driven for four beats");

  // No-op with no read two beats earlier: nothing loads three beats on
  property p_oe_off;
    (k_rise && rd_n && wr_n && $past(rd_n, 2)) |-> ##4 !q_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("outputs still driven after a no-op");

  property p_doff_quiet;
    !doff_n |-> (rd_n && wr_n);
  endproperty
  a_doff_quiet: assert property (p_doff_quiet)
    else $error("command while loop is disabled");

  // No beat edge may arrive while the clock is flagged static
  property p_held_quiet;
    !clk_held;
  endproperty
  a_held_quiet: assert property (p_held_quiet)
    else $error("link clock ran while flagged static");
endmodule : sram_link_assertions

// [testbench/burst4_sram_port_behaviour_tb_top.sv]
`timescale 1ns/1ps
// ==========================================================================
// Bench: controller and memory joined, driven from the user side
module burst4_sram_port_behaviour_tb_top;
  import sram_link_pkg::*;

  localparam logic [BURST_W-1:0] D0 =
    {18'h3a5c1, 18'h12345, 18'h2f0f0, 18'h0e1d2};
  localparam logic [BURST_W-1:0] D1 =
    {18'h11111, 18'h2aaaa, 18'h35555, 18'h0c3c3};

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 4'h0;
  logic [BURST_W-1:0] req_wdata = '0;
  logic [MASK_W-1:0] req_bw_n = 8'hff;
  logic rsp_valid;
  logic rsp_ready = 1'b1;
  logic [BURST_W-1:0] rsp_data;
  logic dll_reset_req = 1'b0;
  logic clk_stop = 1'b0;
  logic use_k_timing = 1'b0;
  logic link_ready;
  logic dll_locked;
  logic out_from_k;
  logic [BURST_W-1:0] img;
  int miscompares = 0;
  int checks = 0;

  // ========================================================================
  // Clock, ends and checker
  always #20 ref_clk = ~ref_clk;

  sram_link lk ();

  sram_burst_ctrl i_sram_burst_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .lk(lk),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_bw_n(req_bw_n),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .dll_reset_req(dll_reset_req), .clk_stop(clk_stop),
    .use_k_timing(use_k_timing), .link_ready(link_ready)
  );

  sram_burst_mem i_sram_burst_mem (
    .lk(lk), .sys_rst(sys_rst), .dll_locked(dll_locked),
    .out_from_k(out_from_k)
  );

  sram_link_assertions i_sram_link_assertions (
    .beat_clk(lk.beat_clk), .sys_rst(sys_rst), .k_rise(lk.k_rise),
    .doff_n(lk.doff_n), .clk_held(lk.clk_held), .rd_n(lk.rd_n),
    .wr_n(lk.wr_n), .q_oe(lk.q_oe)
  );

  // ========================================================================
  // Shared tasks
  task automatic chk(input logic [BURST_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({{(BURST_W-1){1'b0}}, got}, {{(BURST_W-1){1'b0}}, exp});
  endtask : chk1

  // Bytes with a low mask bit take the new value
  function automatic logic [BURST_W-1:0] merge(
      input logic [BURST_W-1:0] old, nw, input logic [MASK_W-1:0] m);
    logic [BURST_W-1:0] r;
    r = old;
    for (int i = 0; i < MASK_W; i++) begin
      if (!m[i]) r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction : merge

  // Relock takes over four thousand cycles, so the bound is generous
  task automatic wait_link();
    int n;
    n = 0;
    while (link_ready !== 1'b1 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
    chk1(link_ready, 1'b1);
    @(posedge ref_clk);
    #1;
  endtask : wait_link

  // Request held until the edge that sees ready high
  task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [BURST_W-1:0] dat, input logic [MASK_W-1:0] m);
    int n;
    req_write = wr;
    req_addr = a;
    req_wdata = dat;
    req_bw_n = m;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    chk1(req_ready, 1'b1);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : send

  // Response compared while it stands, popped on the next edge
  task automatic get(input logic [BURST_W-1:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    chk1(rsp_valid, 1'b1);
    chk(rsp_data, exp);
    @(posedge ref_clk);
    #1;
  endtask : get

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // ========================================================================
  // Scenarios
  task automatic t_lock();
    repeat (4000) @(posedge ref_clk);
    #1;
    chk1(link_ready, 1'b0);
    wait_link();
    chk1(dll_locked, 1'b1);
    $display("test lock done");
  endtask : t_lock

  // Full write, read back, then a masked rewrite of selected bytes
  task automatic t_write_read();
    send(1'b1, 4'h3, D0, 8'h00);
    img = D0;
    send(1'b0, 4'h3, '0, 8'hff);
    get(img);
    send(1'b1, 4'h3, D1, 8'h9c);
    img = merge(img, D1, 8'h9c);
    send(1'b0, 4'h3, '0, 8'hff);
    get(img);
    repeat (20) @(posedge ref_clk);
    #1;
    chk1(lk.q_oe, 1'b0);
    $display("test write_read done");
  endtask : t_write_read

  // Two responses fill the buffer; a third read must wait
  task automatic t_buffer();
    int seen;
    rsp_ready = 1'b0;
    send(1'b0, 4'h3, '0, 8'hff);
    send(1'b0, 4'h3, '0, 8'hff);
    repeat (40) @(posedge ref_clk);
    #1;
    req_write = 1'b0;
    req_valid = 1'b1;
    seen = 0;
    repeat (40) begin
      @(negedge ref_clk);
      if (req_ready === 1'b1) seen++;
    end
    chk1(seen == 0, 1'b1);
    #21;
    req_valid = 1'b0;
    rsp_ready = 1'b1;
    get(img);
    get(img);
    repeat (4) @(posedge ref_clk);
    #1;
    chk1(rsp_valid, 1'b0);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_clock_stop();
    clk_stop = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk1(lk.clk_held, 1'b1);
    chk1(dll_locked, 1'b0);
    chk1(lk.beat_clk, 1'b0);
    clk_stop = 1'b0;
    wait_link();
    send(1'b0, 4'h3, '0, 8'hff);
    get(img);
    $display("test clock_stop done");
  endtask : t_clock_stop

  task automatic t_loop_reset();
    dll_reset_req = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    dll_reset_req = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk1(dll_locked, 1'b0);
    chk1(link_ready, 1'b0);
    wait_link();
    chk1(dll_locked, 1'b1);
    $display("test loop_reset done");
  endtask : t_loop_reset

  // Read timing from the input clock with output clocks tied high
  task automatic t_k_timing();
    use_k_timing = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    chk1(&lk.c_pair, 1'b1);
    chk1(out_from_k, 1'b1);
    // Echo true half follows the input clock marker after a beat edge
    @(posedge lk.beat_clk);
    #1;
    chk1(lk.echo_strobe_pair[0], lk.k_rise);
    chk1(^lk.echo_strobe_pair, 1'b1);
    send(1'b0, 4'h3, '0, 8'hff);
    get(img);
    use_k_timing = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk1(out_from_k, 1'b0);
    chk1(^lk.echo_strobe_pair, 1'b1);
    $display("test k_timing done");
  endtask : t_k_timing

  // ========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_lock();
    t_write_read();
    t_buffer();
    t_clock_stop();
    t_loop_reset();
    t_k_timing();
    summarize();
  end

  // Three lock waits plus traffic stay far below this span
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
endmodule : burst4_sram_port_behaviour_tb_top
